/* File: common/ptb_params.svh */
// register offsets, field positions and reset values for the time-base control
`ifndef PTB_PARAMS_SVH
`define PTB_PARAMS_SVH
`define PTB_OFF_SEL      4'h0
`define PTB_OFF_CTRL     4'h4
`define PTB_OFF_IRQ_STAT 4'h8
`define PTB_OFF_IRQ_CLR  4'hc
`define PTB_SEL_W        6
`define PTB_SEL_RST      6'h3f
`define PTB_SEL_GND      6'h3f
`define PTB_PIN_CNT      36
`define PTB_BIT_ON       15
`define PTB_BIT_IDLE     13
`define PTB_BIT_PEND     12
`define PTB_BIT_IEN      11
`define PTB_BIT_IMM      10
`define PTB_CTRL_WMASK   16'hac00
`endif

/* File: common/ptb_pkg.sv */
// types shared by the time-base control block
package ptb_pkg;
    // control fields as seen by the time base
    typedef struct packed {
        logic on;         // module enable
        logic idle_halt;  // stop in idle
        logic irq_en;     // special event irq enable
        logic imm_update; // immediate period update
    } ptb_ctrl_type;
    // bus slave response codes
    typedef enum logic [1:0] {
        PTB_OKAY = 2'b00,
        PTB_SLVERR = 2'b10
    } ptb_resp_type;
endpackage : ptb_pkg

/* File: src/ptb_ctrl.sv */
// time-base sync input select and control register block
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "ptb_params.svh"
module ptb_ctrl (
    input wire logic aclk,                  // system clock
    input wire logic aresetn,               // sync reset, active low
    input wire logic [3:0] s_axi_awaddr,    // write address
    input wire logic s_axi_awvalid,         // write address valid
    output logic s_axi_awready,             // write address ready
    input wire logic [31:0] s_axi_wdata,    // write data
    input wire logic [3:0] s_axi_wstrb,     // write strobes
    input wire logic s_axi_wvalid,          // write data valid
    output logic s_axi_wready,              // write data ready
    output logic [1:0] s_axi_bresp,         // write response
    output logic s_axi_bvalid,              // write response valid
    input wire logic s_axi_bready,          // write response ready
    input wire logic [3:0] s_axi_araddr,    // read address
    input wire logic s_axi_arvalid,         // read address valid
    output logic s_axi_arready,             // read address ready
    output logic [31:0] s_axi_rdata,        // read data
    output logic [1:0] s_axi_rresp,         // read response
    output logic s_axi_rvalid,              // read data valid
    input wire logic s_axi_rready,          // read data ready
    input wire logic [35:0] remappable_pin, // async remappable pins
    input wire logic cpu_idle,              // cpu in idle, same clock
    input wire logic special_event,         // one-cycle event pulse
    output ptb_pkg::ptb_ctrl_type ctrl,     // control fields out
    output logic time_base_run,             // time base may count
    output logic sync_in2,                  // selected sync input
    output logic irq                        // level interrupt
);
    logic [5:0] sync_in2_pin_sel_ff;   // selector field
    logic [15:0] ctrl_ff;              // control register
    logic irq_stat_ff;                 // sticky special event status
    logic [35:0] pin_meta_ff;          // synchroniser stage one
    logic [35:0] pin_sync_ff;          // synchroniser stage two
    logic sync_in2_ff;                 // registered mux output
    logic aw_got_ff;                   // write address held
    logic w_got_ff;                    // write data held
    logic [3:0] awaddr_ff;             // captured write address
    logic [31:0] wdata_ff;             // captured write data
    logic [3:0] wstrb_ff;              // captured strobes
    logic bvalid_ff;                   // response pending
    logic [1:0] bresp_ff;              // response code
    logic rvalid_ff;                   // read data pending
    logic [31:0] rdata_ff;             // read data
    logic [1:0] rresp_ff;              // read response code
    logic wr_fire;                     // both halves present
    logic clr_pend;                    // software clears status

    // merge byte strobes into a 16-bit register value
    function automatic logic [15:0] strb_merge(input logic [15:0] old,
                                               input logic [31:0] d,
                                               input logic [3:0] s);
        strb_merge = old;
        if (s[0]) strb_merge[7:0] = d[7:0];
        if (s[1]) strb_merge[15:8] = d[15:8];
    endfunction : strb_merge

    // address decode shared by both read and write paths
    function automatic logic addr_ok(input logic [3:0] a);
        addr_ok = (a == `PTB_OFF_SEL) || (a == `PTB_OFF_CTRL) ||
                  (a == `PTB_OFF_IRQ_STAT) || (a == `PTB_OFF_IRQ_CLR);
    endfunction : addr_ok

    // write channels are taken independently, one write in flight
    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // capture address and data halves in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got_ff <= 1'b0;
            end
        end
    end

    // write response, error for unmapped offsets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= ptb_pkg::PTB_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= addr_ok(awaddr_ff) ? ptb_pkg::PTB_OKAY
                                           : ptb_pkg::PTB_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // selector register, only the low six bits exist
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_in2_pin_sel_ff <= `PTB_SEL_RST;
        end else if (wr_fire && awaddr_ff == `PTB_OFF_SEL &&
                     wstrb_ff[0]) begin
            sync_in2_pin_sel_ff <= wdata_ff[5:0];
        end
    end

    // control register; the pending bit is kept apart as sticky status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= 16'h0000;
        end else if (wr_fire && awaddr_ff == `PTB_OFF_CTRL) begin
            ctrl_ff <= strb_merge(ctrl_ff, wdata_ff, wstrb_ff) &
                       `PTB_CTRL_WMASK;
        end
    end

    // software clears pending by writing one to the clear register
    assign clr_pend = wr_fire && awaddr_ff == `PTB_OFF_IRQ_CLR &&
                      wstrb_ff[0] && wdata_ff[0];

    // sticky special event status; a new event beats a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_ff <= 1'b0;
        end else if (special_event) begin
            irq_stat_ff <= 1'b1;
        end else if (clr_pend) begin
            irq_stat_ff <= 1'b0;
        end
    end

    // read path, one outstanding read; clear register reads as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= ptb_pkg::PTB_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= addr_ok(s_axi_araddr) ? ptb_pkg::PTB_OKAY
                                              : ptb_pkg::PTB_SLVERR;
            case (s_axi_araddr)
                `PTB_OFF_SEL:
                    rdata_ff <= {26'h0, sync_in2_pin_sel_ff};
                `PTB_OFF_CTRL: rdata_ff <= {16'h0, ctrl_ff[15:13],
                                            irq_stat_ff, ctrl_ff[11:0]};
                `PTB_OFF_IRQ_STAT: rdata_ff <= {31'h0, irq_stat_ff};
                default: rdata_ff <= 32'h0;
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // pins are asynchronous, two flops before the selector sees them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_ff <= 36'h0;
            pin_sync_ff <= 36'h0;
        end else begin
            pin_meta_ff <= remappable_pin;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // selector mux; unused codes other than all ones also read low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_in2_ff <= 1'b0;
        end else if (sync_in2_pin_sel_ff == `PTB_SEL_GND) begin
            sync_in2_ff <= 1'b0;
        end else if (sync_in2_pin_sel_ff < 6'(`PTB_PIN_CNT)) begin
            sync_in2_ff <= pin_sync_ff[sync_in2_pin_sel_ff];
        end else begin
            sync_in2_ff <= 1'b0;
        end
    end
    assign sync_in2 = sync_in2_ff;

    // control fields and run gating; idle halt only matters when on
    assign ctrl.on = ctrl_ff[`PTB_BIT_ON];
    assign ctrl.idle_halt = ctrl_ff[`PTB_BIT_IDLE];
    assign ctrl.irq_en = ctrl_ff[`PTB_BIT_IEN];
    assign ctrl.imm_update = ctrl_ff[`PTB_BIT_IMM];
    assign time_base_run = ctrl_ff[`PTB_BIT_ON] &&
                           !(ctrl_ff[`PTB_BIT_IDLE] && cpu_idle);
    assign irq = irq_stat_ff && ctrl_ff[`PTB_BIT_IEN];

    // a selector of all ones must hold the sync input low
    property p_gnd_tie;
        @(posedge aclk) disable iff (!aresetn)
        (sync_in2_pin_sel_ff == `PTB_SEL_GND) |=> !sync_in2;
    endproperty
    a_gnd_tie: assert property (p_gnd_tie)
        else $error("sync not low");
    // module off means time base never runs
    property p_off_stops;
        @(posedge aclk) disable iff (!aresetn)
        !ctrl_ff[`PTB_BIT_ON] |-> !time_base_run;
    endproperty
    a_off_stops: assert property (p_off_stops)
        else $error("run when off");
    // idle with halt set stops the time base
    property p_idle_halt;
        @(posedge aclk) disable iff (!aresetn)
        (cpu_idle && ctrl_ff[`PTB_BIT_IDLE]) |-> !time_base_run;
    endproperty
    a_idle_halt: assert property (p_idle_halt)
        else $error("idle run");
    // a valid pin code follows its synchronised pin one cycle later
    property p_pin_follow;
        @(posedge aclk) disable iff (!aresetn)
        (sync_in2_pin_sel_ff < 6'(`PTB_PIN_CNT)) ##0
        (sync_in2_pin_sel_ff == $past(sync_in2_pin_sel_ff))
        |-> sync_in2 == $past(pin_sync_ff[sync_in2_pin_sel_ff]);
    endproperty
    a_pin_follow: assert property (p_pin_follow)
        else $error("mux bad");
    // first edge with reset released
    sequence s_released;
        $rose(aresetn);
    endsequence
    // selector comes out of reset grounded, module disabled
    property p_sel_reset;
        @(posedge aclk) disable iff (!aresetn)
        s_released |-> (sync_in2_pin_sel_ff == `PTB_SEL_RST) &&
                       (ctrl_ff == 16'h0000);
    endproperty
    a_sel_reset: assert property (p_sel_reset)
        else $error("bad reset state");
    // an event always lands in the sticky bit, even against a clear
    property p_event_sticky;
        @(posedge aclk) disable iff (!aresetn)
        special_event |=> irq_stat_ff;
    endproperty
    a_event_sticky: assert property (p_event_sticky)
        else $error("event lost");
    // read address taken this edge
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // read data answers on the edge after the address is taken
    property p_read_answer;
        @(posedge aclk) disable iff (!aresetn)
        s_ar_taken |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("no read answer");
endmodule : ptb_ctrl

/* File: test/ptb_pin_src.sv */
// model of the external sync source on the remappable pins
`timescale 1ns/100ps
module ptb_pin_src (
    input wire logic aclk,                  // system clock
    input wire logic [35:0] level,          // levels commanded by the bench
    output logic [35:0] remappable_pin      // pin levels seen by the block
);
    // pins change one edge after the command, unrelated to the bus traffic
    always_ff @(posedge aclk) begin
        remappable_pin <= level;
    end
endmodule : ptb_pin_src

/* File: test/tb.sv */
// self-checking testbench for the time-base control block
`timescale 1ns/100ps
module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq, sync_in2, run;
    logic cpu_idle, special_event;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [35:0] level, pins;
    logic [15:0] seed;
    logic [5:0] code;
    logic [3:0] wstrb;
    logic [5:0] corner [8] = '{6'h00, 6'h01, 6'h1f, 6'h20, 6'h21, 6'h22,
        6'h23, 6'h3f};
    ptb_pkg::ptb_ctrl_type ctrl;
    int mismatches, checked, i;
    ptb_pin_src ptb_pin_src_inst (.aclk(aclk), .level(level),
        .remappable_pin(pins));
    ptb_ctrl ptb_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .remappable_pin(pins), .cpu_idle(cpu_idle),
        .special_event(special_event), .ctrl(ctrl), .time_base_run(run),
        .sync_in2(sync_in2), .irq(irq));
    // free-running 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // pseudo-random step
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    // codes past the last pin read as ground
    function automatic logic exp_sync(input logic [5:0] c,
        input logic [35:0] p);
        return (c < 6'h24) ? p[c] : 1'b0;
    endfunction : exp_sync
    // compare and count
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // bus write: both halves offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    // bus read: data and response taken at the edge rvalid is seen
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    // verdict and end of run
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    // hang guard, far above the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        end_of_test();
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {cpu_idle, special_event, aresetn} = '0;
        {awaddr, araddr, wdata, level} = '0;
        wstrb = 4'hf;
        seed = 16'hde1b;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0);
        chk("sel_reset", 32'h3f, d);
        chk("sync_reset", 32'h0, {31'h0, sync_in2});
        rd(4'h4);
        chk("ctrl_reset", 32'h0, d);
        $display("reset test done");
        // corner codes first, then random ones; junk in the upper bits
        for (i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            code = (i < 8) ? corner[i] : seed[5:0];
            level <= {seed[3:0], seed, seed ^ 16'ha5c3};
            wr(4'h0, {seed, seed[15:6], code});
            rd(4'h0);
            chk("sel_rw", {26'h0, code}, d);
            repeat (5) @(posedge aclk);
            chk("sync", exp_sync(code, level),
                sync_in2);
            level <= ~level;
            repeat (5) @(posedge aclk);
            chk("sync_inv", exp_sync(code, level), sync_in2);
        end
        $display("selector test done");
        wr(4'h4, 32'hffffffff);
        chk("bresp_ok", 32'h0, {30'h0, r});
        rd(4'h4);
        chk("ctrl_rw", 32'hac00, d);
        chk("ctrl_out", 32'hf, {28'h0, ctrl});
        chk("run", 32'h1, {31'h0, run});
        cpu_idle <= 1'b1;
        @(posedge aclk);
        @(posedge aclk);
        chk("idle_halt", 32'h0, {31'h0, run});
        wr(4'h4, 32'h8c00);
        chk("idle_run", 32'h1, {31'h0, run});
        wr(4'h4, 32'h2c00);
        chk("off", 32'h0, {31'h0, run});
        // low byte strobe only: the upper control byte must stay put
        wstrb <= 4'h1;
        wr(4'h4, 32'h0);
        wstrb <= 4'hf;
        rd(4'h4);
        chk("ctrl_strb", 32'h2c00, d);
        $display("control test done");
        // raise, mask, unmask and clear the special event interrupt
        @(posedge aclk);
        special_event <= 1'b1;
        @(posedge aclk);
        special_event <= 1'b0;
        rd(4'h8);
        chk("pending", 32'h1, d);
        chk("irq_on", 32'h1, {31'h0, irq});
        wr(4'h4, 32'h2400);
        chk("irq_mask", 32'h0, {31'h0, irq});
        wr(4'h4, 32'h2c00);
        chk("irq_unmask", 32'h1, {31'h0, irq});
        wr(4'hc, 32'h1);
        rd(4'h8);
        chk("cleared", 32'h0, d);
        chk("irq_off", 32'h0, {31'h0, irq});
        rd(4'h2);
        chk("unmapped", 32'h2, {30'h0, r});
        wr(4'h2, 32'hffffffff);
        chk("unmapped_wr", 32'h2, {30'h0, r});
        $display("interrupt test done");
        end_of_test();
    end
endmodule : tb
